/* File: logic/mpc_pkg.sv */
// package: melody playback controller constants, tables and types
package mpc_pkg;
  // apb byte address width; register index = byte address / 4
  localparam int APB_AW = 10;
  localparam logic [7:0] IDX_IRQ_EN   = 8'hE7;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'hEC;
  localparam logic [7:0] IDX_ADDR_LO  = 8'hF0;
  localparam logic [7:0] IDX_ADDR_HI  = 8'hF1;
  localparam logic [7:0] IDX_CTRL     = 8'hF2;
  // control register field positions
  localparam int PLAY_B = 0;
  localparam int TSEL_B = 1;
  localparam int SPD_LO = 2;
  localparam int SPD_HI = 3;
  // melody rom word layout and limits
  localparam int W_END = 0;
  localparam int W_SC_LO = 1;
  localparam int W_SC_HI = 4;
  localparam int W_NT_LO = 5;
  localparam int W_NT_HI = 7;
  localparam int W_ATK = 8;
  localparam logic [6:0] ROM_WORDS    = 7'h50;
  localparam logic [3:0] SCALE_SILENT = 4'hF;
  localparam logic [8:0] OOR_WORD     = 9'h1FF; // attack, 32nd, silent, end
  localparam logic [3:0] NIB_RESET    = 4'h0;
  // timing figures in their own units
  localparam longint START_MS    = 64'h7D;  // 125 ms start latency
  localparam longint ATTACK_MS   = 64'h0C;  // 12 ms attack rest
  localparam longint MS_PER_S    = 64'h3E8;
  localparam longint SEC_PER_MIN = 64'h3C;
  localparam longint TEMPO_SCALE = 64'h0A;  // tempos kept in tenths
  localparam longint SLOTS_BEAT  = 64'h08;  // 32nd slots per quarter
  // tempo table in tenths of beats per minute
  localparam logic [15:0] TEMPO_X10 [16] = '{16'h012C, 16'h0140, 16'h0157, 16'h0171, 16'h0190, 16'h01B4,
    16'h01E0, 16'h0215, 16'h0258, 16'h02AE, 16'h0320, 16'h03C0, 16'h04B0, 16'h0640, 16'h0960, 16'h12C0};
  // note length code to number of 32nd slots
  localparam logic [4:0] NOTE_SLOTS [8] = '{5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01};
  // speed field to rate multiplier
  localparam logic [5:0] SPEED_MULT [4] = '{6'h01, 6'h08, 6'h10, 6'h20};
  // tone divider defaults
  localparam logic [15:0] TONE_BASE = 16'h2000;
  localparam logic [15:0] TONE_STEP = 16'h0200;

  typedef enum logic [3:0] {
    MPC_IDLE  = 4'h1,
    MPC_DLY   = 4'h2,
    MPC_FETCH = 4'h4,
    MPC_PLAY  = 4'h8
  } mpc_state_t;

  // clock cycles of one 32nd slot for a tempo code, never below one
  function automatic logic [31:0] mpc_slot_cyc(input logic [3:0] code, input longint clk_hz);
    longint n;
    n = (clk_hz * SEC_PER_MIN * TEMPO_SCALE) / (SLOTS_BEAT * longint'(TEMPO_X10[code]));
    if (n < 1) n = 1;
    return n[31:0];
  endfunction : mpc_slot_cyc

  // clock cycles of a time in ms, rounded down, never below one
  function automatic logic [31:0] mpc_ms_cyc(input longint ms, input longint clk_hz);
    longint n;
    n = (clk_hz * ms) / MS_PER_S;
    if (n < 1) n = 1;
    return n[31:0];
  endfunction : mpc_ms_cyc
endpackage : mpc_pkg

/* File: logic/mpc_tone.sv */
// tone divider: square wave whose half period follows the scale code
`timescale 1ns/1ps
module mpc_tone #(
  parameter logic [15:0] BASE = mpc_pkg::TONE_BASE,
  parameter logic [15:0] STEP = mpc_pkg::TONE_STEP
) (
  // clock, reset and clock enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // tone request
  input  wire logic       en,
  input  wire logic [3:0] scale,
  // square wave
  output logic            sq
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        sq;
  } mpc_tone_st_t;

  mpc_tone_st_t s, n;
  logic [15:0]  half;

  assign sq = s.sq;

  // divider restarts whenever the tone is muted so each note starts clean
  always_comb begin
    n    = s;
    half = 16'(BASE + 16'(scale) * STEP);
    if (!en) begin
      n.cnt = 16'h0000;
      n.sq  = 1'b1;
    end else if (s.cnt >= half) begin
      n.cnt = 16'h0000;
      n.sq  = ~s.sq;
    end else begin
      n.cnt = s.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{cnt: 16'h0000, sq: 1'b1};
    end else if (ce) begin
      s <= n;
    end
  end
endmodule : mpc_tone

/* File: logic/mpc_ctrl.sv */
// melody playback controller: apb registers, sequencer, timing and buzzer outputs
`timescale 1ns/1ps
module mpc_ctrl #(
  parameter longint     CLK_HZ      = 64'h0000_0000_02FA_F080,
  parameter logic [3:0] TEMPO0_CODE = 4'h0,
  parameter logic [3:0] TEMPO1_CODE = 4'hC
) (
  // clock, reset, enable
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST,
  input  wire logic                       CLK_EN,
  // apb slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [mpc_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // melody rom, asynchronous read
  output logic      [6:0]                 ROM_ADDR,
  input  wire logic [8:0]                 ROM_DATA,
  // buzzer and interrupt
  output logic                            MELODY_OUT,
  output logic                            MELODY_OUT_N,
  output logic                            MELODY_IRQ
);
  // tempo code table lookup
  // both tempos are fixed at build time, so the table costs no gates
  localparam logic [31:0] SLOT0_CYC = mpc_pkg::mpc_slot_cyc(TEMPO0_CODE, CLK_HZ);
  localparam logic [31:0] SLOT1_CYC = mpc_pkg::mpc_slot_cyc(TEMPO1_CODE, CLK_HZ);
  localparam logic [31:0] START_CYC = mpc_pkg::mpc_ms_cyc(mpc_pkg::START_MS, CLK_HZ);
  localparam logic [31:0] ATK_CYC   = mpc_pkg::mpc_ms_cyc(mpc_pkg::ATTACK_MS, CLK_HZ);

  typedef struct packed {
    mpc_pkg::mpc_state_t st;
    logic        irq_en;
    logic        flag;
    logic [3:0]  addr_lo;
    logic [2:0]  addr_hi;
    logic        play;
    logic        tsel;
    logic [1:0]  speed;
    logic        tsel_run;
    logic [6:0]  ptr;
    logic        wait_f;
    logic        first;
    logic        rest;
    logic        end_f;
    logic [3:0]  scale;
    logic [4:0]  slots;
    logic [4:0]  slot_cnt;
    logic [31:0] acc;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mo;
    logic        mo_n;
    logic        irq;
  } mpc_st_t;

  mpc_st_t     s, n;
  logic        setup, acc_ph, wr, rd, hit;
  logic [7:0]  idx;
  logic        start, tick, end_evt, sounding, tone_sq;
  logic [31:0] target, sum;
  logic [8:0]  word;

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign PRDATA       = s.prdata;
  assign PREADY       = s.pready;
  assign PSLVERR      = s.pslverr;
  assign ROM_ADDR     = s.ptr;
  assign MELODY_OUT   = s.mo;
  assign MELODY_OUT_N = s.mo_n;
  assign MELODY_IRQ   = s.irq;

  // tone is muted during attack rest and on silent scale codes
  assign sounding = (s.st == mpc_pkg::MPC_PLAY) && !s.rest && (s.scale != mpc_pkg::SCALE_SILENT);

  mpc_tone u_tone (
    .clk   (CLK_SYS),
    .rst   (RST),
    .ce    (CLK_EN),
    .en    (sounding),
    .scale (s.scale),
    .sq    (tone_sq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n       = s;
    start   = 1'b0;
    tick    = 1'b0;
    end_evt = 1'b0;
    word    = ROM_DATA;
    setup   = PSEL && !PENABLE;
    acc_ph  = PSEL && PENABLE && s.pready;
    idx     = PADDR[mpc_pkg::APB_AW-1:2];
    wr      = acc_ph && PWRITE && !s.pslverr;
    rd      = acc_ph && !PWRITE && !s.pslverr;
    hit     = (idx == mpc_pkg::IDX_IRQ_EN) || (idx == mpc_pkg::IDX_IRQ_FLAG) || (idx == mpc_pkg::IDX_ADDR_LO)
              || (idx == mpc_pkg::IDX_ADDR_HI) || (idx == mpc_pkg::IDX_CTRL);

    // answer registered in setup, shown in the first access cycle
    n.pready = setup;
    if (setup) begin
      n.pslverr = !hit;
      n.prdata  = 32'h0000_0000;
      case (idx)
        mpc_pkg::IDX_IRQ_EN:   n.prdata[0] = s.irq_en;
        mpc_pkg::IDX_IRQ_FLAG: n.prdata[0] = s.flag;
        mpc_pkg::IDX_ADDR_LO:  n.prdata[3:0] = s.addr_lo;
        mpc_pkg::IDX_ADDR_HI:  n.prdata[2:0] = s.addr_hi;
        mpc_pkg::IDX_CTRL:     n.prdata[3:0] = {s.speed, s.tsel, s.play};
        default:               n.prdata = 32'h0000_0000;
      endcase
    end

    // register writes; the flag register ignores writes
    if (wr) begin
      case (idx)
        mpc_pkg::IDX_IRQ_EN:  n.irq_en = PWDATA[0];
        mpc_pkg::IDX_ADDR_LO: n.addr_lo = PWDATA[3:0];
        mpc_pkg::IDX_ADDR_HI: n.addr_hi = PWDATA[2:0];
        mpc_pkg::IDX_CTRL: begin
          n.play  = PWDATA[mpc_pkg::PLAY_B];
          n.tsel  = PWDATA[mpc_pkg::TSEL_B];
          n.speed = PWDATA[mpc_pkg::SPD_HI:mpc_pkg::SPD_LO];
          start   = PWDATA[mpc_pkg::PLAY_B] && !s.play;
        end
        default: n.irq_en = s.irq_en;
      endcase
    end

    // weighted timebase: speed is read live so a change acts on the next cycle
    // tempo and speed scaling
    target = s.tsel_run ? SLOT1_CYC : SLOT0_CYC;
    if (s.st == mpc_pkg::MPC_DLY) target = START_CYC;
    else if (s.rest) target = ATK_CYC;
    sum = s.acc + {26'h000_0000, mpc_pkg::SPEED_MULT[s.speed]};
    if ((s.st == mpc_pkg::MPC_DLY) || (s.st == mpc_pkg::MPC_PLAY)) begin
      if (sum >= target) begin
        tick  = 1'b1;
        n.acc = 32'h0000_0000;
      end else begin
        n.acc = sum;
      end
    end

    // sequencer
    case (s.st)
      mpc_pkg::MPC_IDLE: n.acc = 32'h0000_0000;
      mpc_pkg::MPC_DLY: begin
        if (tick) begin
          n.st     = mpc_pkg::MPC_FETCH;
          n.wait_f = 1'b0;
        end
      end
      mpc_pkg::MPC_FETCH: begin
        // one cycle for the rom address to settle before capture
        if (!s.wait_f) begin
          n.wait_f = 1'b1;
        end else begin
          if (s.ptr >= mpc_pkg::ROM_WORDS) word = mpc_pkg::OOR_WORD;
          n.wait_f   = 1'b0;
          n.end_f    = word[mpc_pkg::W_END];
          n.scale    = word[mpc_pkg::W_SC_HI:mpc_pkg::W_SC_LO];
          n.slots    = mpc_pkg::NOTE_SLOTS[word[mpc_pkg::W_NT_HI:mpc_pkg::W_NT_LO]];
          n.rest     = word[mpc_pkg::W_ATK];
          n.slot_cnt = 5'h00;
          n.acc      = 32'h0000_0000;
          // a melody whose first word lacks attack plays nothing
          n.st       = (s.first && !word[mpc_pkg::W_ATK]) ? mpc_pkg::MPC_IDLE : mpc_pkg::MPC_PLAY;
        end
      end
      mpc_pkg::MPC_PLAY: begin
        if (tick && s.rest) begin
          n.rest = 1'b0;
        end else if (tick && (s.slot_cnt + 5'h01 != s.slots)) begin
          n.slot_cnt = s.slot_cnt + 5'h01;
        end else if (tick) begin
          n.slot_cnt = 5'h00;
          n.st       = mpc_pkg::MPC_FETCH;
          n.first    = 1'b0;
          n.ptr      = s.ptr + 7'h01;
          if (s.end_f) begin
            end_evt = 1'b1;
            n.ptr      = {s.addr_hi, s.addr_lo};
            n.tsel_run = s.tsel;
            n.first    = 1'b1;
            // halt when play bit is clear
            if (!s.play) n.st = mpc_pkg::MPC_IDLE;
          end
        end
      end
      default: n.st = mpc_pkg::MPC_IDLE;
    endcase

    if (start) begin
      n.st       = mpc_pkg::MPC_DLY;
      n.ptr      = {s.addr_hi, s.addr_lo};
      // tempo written with the play bit
      // a select written together with play belongs to the melody it starts
      n.tsel_run = n.tsel;
      n.first    = 1'b1;
      n.rest     = 1'b0;
      n.acc      = 32'h0000_0000;
    end

    // read clears only what was shown; a new event wins
    n.flag = end_evt || (s.flag && !(rd && (idx == mpc_pkg::IDX_IRQ_FLAG) && s.prdata[0]));
    n.irq  = s.flag && s.irq_en;

    // both pins high when not sounding, complementary while sounding
    n.mo   = sounding ? tone_sq : 1'b1;
    n.mo_n = sounding ? !tone_sq : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s <= '{st: mpc_pkg::MPC_IDLE, addr_lo: mpc_pkg::NIB_RESET, scale: mpc_pkg::SCALE_SILENT,
             mo: 1'b1, mo_n: 1'b1, default: '0};
    end else if (CLK_EN) begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_flag_set;
    @(posedge CLK_SYS) disable iff (RST) CLK_EN && end_evt |=> s.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("end event did not set flag");

  property p_irq_mask;
    @(posedge CLK_SYS) disable iff (RST) CLK_EN && s.flag && s.irq_en |=> MELODY_IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("enabled flag gave no request");

  property p_irq_off;
    @(posedge CLK_SYS) disable iff (RST) CLK_EN && !s.irq_en |=> !MELODY_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked flag raised request");

  property p_halt;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && end_evt && !s.play && !start |=> s.st == mpc_pkg::MPC_IDLE ##1 MELODY_OUT && MELODY_OUT_N;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt at end with play clear");

  property p_repeat;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && end_evt && s.play && !start |=> s.st == mpc_pkg::MPC_FETCH && s.ptr == $past({s.addr_hi, s.addr_lo});
  endproperty
  a_repeat: assert property (p_repeat) else $error("no continue at start address");

  property p_restart;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && start |=> s.st == mpc_pkg::MPC_DLY && s.ptr == $past({s.addr_hi, s.addr_lo});
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_tempo_hold;
    @(posedge CLK_SYS) disable iff (RST) CLK_EN && !start && !end_evt |=> $stable(s.tsel_run);
  endproperty
  a_tempo_hold: assert property (p_tempo_hold) else $error("tempo changed mid melody");

  property p_rd_clr;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && rd && idx == mpc_pkg::IDX_IRQ_FLAG && s.prdata[0] && !end_evt |=> !s.flag;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("flag read did not clear");

  property p_advance;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && s.st == mpc_pkg::MPC_PLAY && tick && !s.rest && s.slot_cnt + 5'h01 == s.slots && !s.end_f && !start
      |=> s.ptr == $past(s.ptr) + 7'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("address did not advance");

  property p_oor;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && s.st == mpc_pkg::MPC_FETCH && s.wait_f && s.ptr >= mpc_pkg::ROM_WORDS && !start
      |=> s.slots == 5'h01 && s.scale == mpc_pkg::SCALE_SILENT && s.end_f;
  endproperty
  a_oor: assert property (p_oor) else $error("out of range word not silent");

  property p_addr_wr;
    @(posedge CLK_SYS) disable iff (RST)
      CLK_EN && wr && idx == mpc_pkg::IDX_ADDR_LO |=> s.addr_lo == $past(PWDATA[3:0]);
  endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("address nibble not written");

  // the start wait must stay silent on both buzzer pins
  property p_dly_quiet;
    @(posedge CLK_SYS) disable iff (RST) CLK_EN && s.st == mpc_pkg::MPC_DLY |=> MELODY_OUT && MELODY_OUT_N;
  endproperty
  a_dly_quiet: assert property (p_dly_quiet) else $error("sound during start wait");

  c_end:     cover property (@(posedge CLK_SYS) disable iff (RST) end_evt);
  c_restart: cover property (@(posedge CLK_SYS) disable iff (RST) start && s.st == mpc_pkg::MPC_PLAY);
  c_tone:    cover property (@(posedge CLK_SYS) disable iff (RST) sounding ##1 !MELODY_OUT);
  c_oor:     cover property (@(posedge CLK_SYS) disable iff (RST)
    s.st == mpc_pkg::MPC_FETCH && s.ptr >= mpc_pkg::ROM_WORDS);
endmodule : mpc_ctrl

/* File: verif/mpc_rom_model.sv */
// melody rom and piezo sink seen from the controller's far side
`timescale 1ns/1ps
module mpc_rom_model (
  // rom port
  input  wire logic [6:0] rom_addr,
  output logic      [8:0] rom_data,
  // buzzer pins
  input  wire logic       buzz_p,
  input  wire logic       buzz_n,
  output logic            sounding
);
  logic [8:0] mem [80];

  ////////////////////////////////////////////////////////////////////////////
  // rom contents: tiny melodies for the bench
  // attack in first words
  initial begin
    foreach (mem[i]) mem[i] = 9'h000;
    mem[0] = 9'h1E1; // one 32nd, end
    mem[1] = 9'h1E0; // first of two 32nds
    mem[2] = 9'h1E1; // second, end
    mem[3] = 9'h101; // half note, end
  end

  // nothing answers above the rom, so the lines wander instead of holding a value
  always_comb begin
    if (rom_addr < 7'h50) begin
      rom_data = mem[rom_addr];
    end else begin
      rom_data = {rom_addr[1:0], ~rom_addr};
    end
  end

  // the piezo only moves while the two pins differ
  assign sounding = (buzz_p !== buzz_n);
endmodule : mpc_rom_model

/* File: verif/melody_playback_controller_tb_top.sv */
// testbench: apb driven checks of the melody playback controller
`timescale 1ns/1ps
module melody_playback_controller_tb_top;
  localparam longint HZ   = 64'h1F40; // small clock figure keeps counts short
  localparam int     STRT = 1000;     // 125 ms start wait
  localparam int     ATK  = 96;       // 12 ms attack rest
  localparam int     SLF  = 8000 * 600 / (8 * int'(mpc_pkg::TEMPO_X10[15]));
  localparam int     SLC  = 8000 * 600 / (8 * int'(mpc_pkg::TEMPO_X10[12]));

  logic                       clk;
  logic                       rst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [mpc_pkg::APB_AW-1:0] paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [6:0]                 rom_addr;
  logic [8:0]                 rom_data;
  logic                       mel_out;
  logic                       mel_out_n;
  logic                       mel_irq;
  logic                       snd;
  logic [31:0]                d;
  logic                       e;
  int                         n;
  int                         m;
  int                         cycles;
  int                         miscompares;
  int                         comparisons;

  mpc_ctrl #(.CLK_HZ(HZ), .TEMPO0_CODE(4'hF), .TEMPO1_CODE(4'hC)) dut (
    .CLK_SYS(clk), .RST(rst), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ROM_ADDR(rom_addr), .ROM_DATA(rom_data), .MELODY_OUT(mel_out), .MELODY_OUT_N(mel_out_n),
    .MELODY_IRQ(mel_irq));

  mpc_rom_model rom (
    .rom_addr(rom_addr), .rom_data(rom_data), .buzz_p(mel_out), .buzz_n(mel_out_n), .sounding(snd));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard, about three times the expected run
  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      miscompares++;
      $display("[FAIL] timeout expected %0d seen %0d", 50000, cycles);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // measured counts drift by a few cycles of pipeline, hence a tolerance
  task automatic near(input string what, input int exp, input int got, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near

  ////////////////////////////////////////////////////////////////////////////
  // apb transfer: hold everything until pready is seen high
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // values read here are those sampled at this rising edge; only the hang guard ends the wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    logic        x;
    xfer(idx, 1'b1, wd, r, x);
  endtask : wr

  // wait for sound (0), silence (1), bounded by lim
  task automatic wt(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      @(negedge clk);
      if ((sel == 0 && snd === 1'b1) || (sel == 1 && snd === 1'b0)) break;
      cnt++;
    end
  endtask : wt

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    cycles = 0;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // register reset values and access kinds
    xfer(mpc_pkg::IDX_IRQ_EN, 1'b0, 32'h0, d, e);
    chk("irq_enable reset", 32'h0, d);
    xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
    chk("irq_flag reset", 32'h0, d);
    xfer(mpc_pkg::IDX_ADDR_LO, 1'b0, 32'h0, d, e);
    chk("start_addr_low reset", 32'h0, d);
    wr(mpc_pkg::IDX_ADDR_LO, 32'hFFFF_FFFA);
    xfer(mpc_pkg::IDX_ADDR_LO, 1'b0, 32'h0, d, e);
    chk("start_addr_low rw", 32'hA, d);
    wr(mpc_pkg::IDX_IRQ_FLAG, 32'h1);
    xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
    chk("irq_flag write ignored", 32'h0, d);
    xfer(8'h00, 1'b0, 32'h0, d, e);
    chk("unmapped slverr", 32'h1, {31'h0, e});
    wr(mpc_pkg::IDX_ADDR_LO, 32'h0);
    wr(mpc_pkg::IDX_IRQ_EN, 32'h1);
    // one shot at each speed
    for (int s = 0; s < 4; s++) begin
      m = (s == 0) ? 1 : (4 << s);
      wr(mpc_pkg::IDX_CTRL, {28'h0, 2'(s), 2'h1});
      wr(mpc_pkg::IDX_CTRL, {28'h0, 2'(s), 2'h0});
      wt(0, 1500, n);
      near("start wait", (STRT + ATK) / m + 2, n + 4, 6);
      wt(1, 300, n);
      near("note length", (SLF + m - 1) / m, n, 3);
      repeat (3) @(negedge clk);
      chk("irq raised", 32'h1, {31'h0, mel_irq});
      xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
      chk("flag set", 32'h1, d);
      xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
      chk("flag read clear", 32'h0, d);
      wt(0, 1500, n);
      near("halt after end", 1500, n, 0);
    end
    // second tempo with the request masked
    wr(mpc_pkg::IDX_IRQ_EN, 32'h0);
    wr(mpc_pkg::IDX_CTRL, 32'h3);
    wr(mpc_pkg::IDX_CTRL, 32'h2);
    wt(0, 1500, n);
    wt(1, 700, n);
    near("tempo one note", SLC, n, 3);
    repeat (3) @(negedge clk);
    chk("masked irq", 32'h0, {31'h0, mel_irq});
    xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
    chk("flag while masked", 32'h1, d);
    // level hold: tempo held mid melody, new address picked up at the end
    wr(mpc_pkg::IDX_ADDR_LO, 32'h1);
    wr(mpc_pkg::IDX_CTRL, 32'h1);
    wt(0, 1500, n);
    wt(1, 300, n);
    wr(mpc_pkg::IDX_CTRL, 32'h3);
    wr(mpc_pkg::IDX_ADDR_LO, 32'h0);
    wt(0, 300, n);
    wt(1, 700, n);
    near("tempo held", SLF, n, 3);
    wt(0, 300, n);
    near("continue gap", ATK + 2, n + 4, 6);
    chk("continue address", 32'h0, {25'h0, rom_addr});
    wr(mpc_pkg::IDX_CTRL, 32'h2);
    wt(1, 700, n);
    near("next melody tempo", SLC, n + 4, 6);
    wt(0, 1500, n);
    near("level hold stop", 1500, n, 0);
    xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
    // forced stop through a silent out-of-rom melody
    wr(mpc_pkg::IDX_ADDR_LO, 32'h3);
    wr(mpc_pkg::IDX_CTRL, 32'h1);
    wt(0, 1500, n);
    wr(mpc_pkg::IDX_ADDR_HI, 32'h5);
    wr(mpc_pkg::IDX_ADDR_LO, 32'h0);
    wr(mpc_pkg::IDX_CTRL, 32'h0);
    wr(mpc_pkg::IDX_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk("restart address", 32'h50, {25'h0, rom_addr});
    chk("restart quiet", 32'h0, {31'h0, snd});
    wr(mpc_pkg::IDX_CTRL, 32'h0);
    wt(0, 1400, n);
    near("silent notes", 1400, n, 0);
    xfer(mpc_pkg::IDX_IRQ_FLAG, 1'b0, 32'h0, d, e);
    chk("silent melody end", 32'h1, d);
    tally_and_finish();
  end
endmodule : melody_playback_controller_tb_top
